// ### include/wake_coe_pkg.sv
package wake_coe_pkg;

    // MAC register indexes
    localparam logic [7:0]  CSR_WAKE_IDX        = 8'h0c;
    localparam logic [7:0]  CSR_CHECKSUM_IDX    = 8'h0d;
    localparam logic [7:0]  CSR_PHY_ACCESS_IDX  = 8'h06;
    localparam logic [7:0]  CSR_PHY_DATA_IDX    = 8'h07;

    // wake_control_status fields
    localparam int          WAKE_GUE_BIT        = 9;
    localparam int          WAKE_WAKE_FRAME_RECEIVED_BIT       = 6;
    localparam int          WAKE_MPR_BIT        = 5;
    localparam int          WAKE_WAKE_FRAME_ENABLE_BIT       = 2;
    localparam int          WAKE_MAGIC_PACKET_WAKE_ENABLE_BIT       = 1;
    localparam logic [31:0] WAKE_RESET          = 32'h0000_0000;

    // checksum_engine_control fields
    localparam int          CSUM_TX_EN_BIT      = 16;
    localparam int          CSUM_RX_MODE_BIT    = 1;
    localparam int          CSUM_RX_EN_BIT      = 0;
    localparam logic [31:0] CSUM_RESET          = 32'h0000_0000;
    localparam logic [7:0]  RX_CSUM_FIXED_SKIP  = 8'h0e;

    // phy_access_command fields
    localparam int          PHY_ACC_BUSY_BIT    = 0;
    localparam int          PHY_ACC_WRITE_BIT   = 1;
    localparam int          PHY_ACC_INDEX_LSB   = 6;
    localparam int          PHY_INDEX_W         = 5;

    // PHY register indexes
    localparam logic [4:0]  PHY_IDX_BASIC_CTRL  = 5'h00;
    localparam logic [4:0]  PHY_IDX_BASIC_STAT  = 5'h01;
    localparam logic [4:0]  PHY_IDX_ID1         = 5'h02;
    localparam logic [4:0]  PHY_IDX_ID2         = 5'h03;
    localparam logic [4:0]  PHY_IDX_AN_ADV      = 5'h04;
    localparam logic [4:0]  PHY_IDX_AN_PARTNER  = 5'h05;
    localparam logic [4:0]  PHY_IDX_AN_EXP      = 5'h06;
    localparam logic [4:0]  PHY_IDX_MODE_CTRL   = 5'h11;
    localparam logic [4:0]  PHY_IDX_SPEC_MODES  = 5'h12;
    localparam logic [4:0]  PHY_IDX_SPEC_IND    = 5'h1b;
    localparam logic [4:0]  PHY_IDX_INT_SRC     = 5'h1d;
    localparam logic [4:0]  PHY_IDX_INT_MASK    = 5'h1e;
    localparam logic [4:0]  PHY_IDX_SPEC_CTRL   = 5'h1f;

    // basic control fields
    localparam int          BCR_RESET_BIT       = 15;
    localparam int          BCR_LOOPBACK_BIT    = 14;
    localparam int          BCR_SPEED_BIT       = 13;
    localparam int          BCR_AN_EN_BIT       = 12;
    localparam int          BCR_PDOWN_BIT       = 11;
    localparam int          BCR_AN_RESTART_BIT  = 9;
    localparam int          BCR_DUPLEX_BIT      = 8;
    localparam int          BCR_COL_TEST_BIT    = 7;
    localparam logic [15:0] BCR_STORE_MASK      = 16'h7980;
    localparam logic [15:0] BCR_RESET           = 16'h3100;
    localparam logic [15:0] KEPT_OVER_SOFT_RESET = 16'h0000;

    // basic status fields
    localparam int          BSR_AN_DONE_BIT     = 5;
    localparam int          BSR_LINK_BIT        = 2;
    localparam logic [15:0] BSR_FIXED           = 16'h7809;

    typedef struct packed {
        logic rx_frame_done;
        logic dest_addr_lsb;
        logic wake_frame_match;
        logic magic_packet_match;
    } rx_wake_event_s;

    typedef struct packed {
        logic tx_checksum_engine_enable;
        logic rx_checksum_engine_enable;
        logic rx_checksum_start_mode;
    } checksum_ctrl_s;

    typedef struct packed {
        logic soft_reset;
        logic loopback;
        logic speed_100;
        logic full_duplex;
        logic power_down;
        logic collision_test;
        logic an_restart;
        logic an_complete;
    } phy_mode_s;

    typedef enum logic [3:0] {
        AN_OFF  = 4'b0001,
        AN_RUN  = 4'b0010,
        AN_DONE = 4'b0100,
        AN_DOWN = 4'b1000
    } an_state_e;

endpackage

// ### verilog/phy_basic_control.sv
`timescale 1ns/10ps
module phy_basic_control
    import wake_coe_pkg::*;
(
    // clock and reset
    input  wire logic        sys_clk_i,
    input  wire logic        rst_b_i,
    // indexed register port
    input  wire logic        reg_wr_i,
    input  wire logic [4:0]  reg_index_i,
    input  wire logic [15:0] reg_wdata_i,
    output logic      [15:0] reg_rdata_o,
    // line side pins
    input  wire logic        partner_ok_i,
    input  wire logic        partner_speed_100_i,
    input  wire logic        partner_full_duplex_i,
    // mode to the PHY
    output phy_mode_s        phy_mode_o
);

    typedef struct packed {
        logic [2:0]  sync1;
        logic [2:0]  sync2;
        logic [15:0] ctrl;
        logic        reset_pend;
        logic        restart_pend;
        logic        an_speed;
        logic        an_duplex;
        an_state_e   an;
        phy_mode_s   mode;
    } phy_state_s;

    phy_state_s st_ff;
    phy_state_s nxt_st;

    always_comb begin
        nxt_st       = st_ff;
        nxt_st.sync1 = {partner_ok_i, partner_speed_100_i, partner_full_duplex_i};
        nxt_st.sync2 = st_ff.sync1;
        if (st_ff.reset_pend) begin
            nxt_st.ctrl = (BCR_RESET & ~KEPT_OVER_SOFT_RESET)
                        | (st_ff.ctrl & KEPT_OVER_SOFT_RESET);
            nxt_st.reset_pend   = 1'b0;
            nxt_st.restart_pend = 1'b0;
            nxt_st.an           = AN_RUN;
        end else begin
            nxt_st.restart_pend = 1'b0;
            if (reg_wr_i && reg_index_i == PHY_IDX_BASIC_CTRL) begin
                nxt_st.ctrl         = reg_wdata_i & BCR_STORE_MASK;
                nxt_st.reset_pend   = reg_wdata_i[BCR_RESET_BIT];
                nxt_st.restart_pend = reg_wdata_i[BCR_AN_RESTART_BIT];
            end
            unique case (st_ff.an)
                AN_OFF: begin
                    if (st_ff.ctrl[BCR_AN_EN_BIT]) begin
                        nxt_st.an = AN_RUN;
                    end
                end
                AN_RUN: begin
                    if (st_ff.sync2[2]) begin
                        nxt_st.an        = AN_DONE;
                        nxt_st.an_speed  = st_ff.sync2[1];
                        nxt_st.an_duplex = st_ff.sync2[0];
                        nxt_st.ctrl[BCR_SPEED_BIT]  = st_ff.sync2[1];
                        nxt_st.ctrl[BCR_DUPLEX_BIT] = st_ff.sync2[0];
                    end
                end
                AN_DONE: begin
                    if (st_ff.restart_pend) begin
                        nxt_st.an = AN_RUN;
                    end
                end
                AN_DOWN: begin
                    if (!st_ff.ctrl[BCR_PDOWN_BIT]) begin
                        nxt_st.an = AN_RUN;
                    end
                end
            endcase
            // new value, so done never overlaps power-down
            // clearing enable stops negotiation
            if (!nxt_st.ctrl[BCR_AN_EN_BIT]) begin
                nxt_st.an = AN_OFF;
            end
            if (nxt_st.ctrl[BCR_PDOWN_BIT]) begin
                nxt_st.an = AN_DOWN;
            end
        end
        nxt_st.mode.soft_reset     = nxt_st.reset_pend;
        nxt_st.mode.loopback       = nxt_st.ctrl[BCR_LOOPBACK_BIT];
        nxt_st.mode.speed_100      = nxt_st.ctrl[BCR_AN_EN_BIT] ? nxt_st.an_speed
                                                                : nxt_st.ctrl[BCR_SPEED_BIT];
        nxt_st.mode.full_duplex    = nxt_st.ctrl[BCR_AN_EN_BIT] ? nxt_st.an_duplex
                                                                : nxt_st.ctrl[BCR_DUPLEX_BIT];
        nxt_st.mode.power_down     = nxt_st.ctrl[BCR_PDOWN_BIT];
        nxt_st.mode.collision_test = nxt_st.ctrl[BCR_COL_TEST_BIT];
        nxt_st.mode.an_restart     = nxt_st.restart_pend;
        nxt_st.mode.an_complete    = (nxt_st.an == AN_DONE);
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_ff      <= '0;
            st_ff.ctrl <= BCR_RESET;
            st_ff.an   <= AN_RUN;
        end else begin
            st_ff <= nxt_st;
        end
    end

    always_comb begin
        reg_rdata_o = 16'h0000;
        unique case (reg_index_i)
            PHY_IDX_BASIC_CTRL: begin
                reg_rdata_o                     = st_ff.ctrl;
                reg_rdata_o[BCR_RESET_BIT]      = st_ff.reset_pend;
                reg_rdata_o[BCR_AN_RESTART_BIT] = st_ff.restart_pend;
            end
            PHY_IDX_BASIC_STAT: begin
                reg_rdata_o                  = BSR_FIXED;
                reg_rdata_o[BSR_AN_DONE_BIT] = (st_ff.an == AN_DONE);
                reg_rdata_o[BSR_LINK_BIT]    = st_ff.sync2[2];
            end
            PHY_IDX_ID1, PHY_IDX_ID2, PHY_IDX_AN_ADV, PHY_IDX_AN_PARTNER,
            PHY_IDX_AN_EXP, PHY_IDX_MODE_CTRL, PHY_IDX_SPEC_MODES,
            PHY_IDX_SPEC_IND, PHY_IDX_INT_SRC, PHY_IDX_INT_MASK,
            PHY_IDX_SPEC_CTRL: begin
                // held in the PHY proper, not in this bank
                reg_rdata_o = 16'h0000;
            end
            default: begin
                reg_rdata_o = 16'h0000;
            end
        endcase
    end

    assign phy_mode_o = st_ff.mode;

endmodule

// ### verilog/wake_coe_phy_control_regs.sv
`timescale 1ns/10ps
// Operation
// - unicast frame wakes when global unicast enabled
// - valid wake frame sets wake-received flag
// - valid magic packet sets magic flag
// - wake-frame enable arms filter-based wake detection
// - magic enable arms magic packet wake
// - tx checksum engine bypassed or enabled
// - rx start: after 14 bytes or L3
// - rx checksum engine enable, rx-idle changes only; the enable here takes a write at any time
// - PHY registers reached indirectly by index
// - PHY index map 0-6,17,18,27,29-31
// - kept fields survive only PHY soft reset
// - bit 15 resets PHY, self-clears
// - bit 14 selects loopback, resets zero
// - bit 13 speed, ignored under negotiation
// - bit 12 enables negotiation, default one
// - bit 11 powers down; clears completion status
// - bit 9 restarts negotiation, self-clears
// - bit 8 duplex, ignored under negotiation
// - bit 7 enables collision test
// - status bit 5 shows negotiation complete
module wake_coe_phy_control_regs
    import wake_coe_pkg::*;
(
    // clock and reset
    input  wire logic           sys_clk_i,
    input  wire logic           rst_b_i,
    // indexed MAC register port
    input  wire logic           csr_wr_i,
    input  wire logic           csr_rd_i,
    input  wire logic [7:0]     csr_index_i,
    input  wire logic [31:0]    csr_wdata_i,
    output logic      [31:0]    csr_rdata_o,
    output logic                csr_rdata_valid_o,
    // receive path events and power state
    input  wire rx_wake_event_s rx_event_i,
    input  wire logic           power_save_i,
    output logic                wake_o,
    // checksum engines
    output checksum_ctrl_s      checksum_o,
    output logic      [7:0]     rx_checksum_skip_o,
    // PHY line pins
    input  wire logic           partner_ok_i,
    input  wire logic           partner_speed_100_i,
    input  wire logic           partner_full_duplex_i,
    output phy_mode_s           phy_mode_o
);

    typedef struct packed {
        logic           global_unicast_wake_enable;
        logic           wake_frame_received;
        logic           magic_packet_received;
        logic           wake_frame_enable;
        logic           magic_packet_wake_enable;
        checksum_ctrl_s csum;
        logic [7:0]     skip;
        logic           acc_busy;
        logic           acc_write;
        logic [4:0]     acc_index;
        logic [15:0]    phy_data;
        logic [31:0]    rdata;
        logic           rdata_valid;
        logic           wake;
    } mac_state_s;

    mac_state_s  st_ff;
    mac_state_s  nxt_st;

    logic        phy_wr;
    logic [15:0] phy_rdata;
    logic        hit_wake;
    logic        hit_csum;
    logic        hit_acc;
    logic        hit_data;
    logic        unicast_hit;
    logic        wake_frame_hit;
    logic        magic_hit;
    logic [31:0] wake_view;
    logic [31:0] csum_view;
    logic [31:0] acc_view;

    assign hit_wake = (csr_index_i == CSR_WAKE_IDX);
    assign hit_csum = (csr_index_i == CSR_CHECKSUM_IDX);
    assign hit_acc  = (csr_index_i == CSR_PHY_ACCESS_IDX);
    assign hit_data = (csr_index_i == CSR_PHY_DATA_IDX);

    // frame qualifiers
    always_comb begin
        unicast_hit    = rx_event_i.rx_frame_done && !rx_event_i.dest_addr_lsb
                       && st_ff.global_unicast_wake_enable;
        wake_frame_hit = rx_event_i.rx_frame_done && rx_event_i.wake_frame_match
                       && st_ff.wake_frame_enable;
        magic_hit      = rx_event_i.rx_frame_done && rx_event_i.magic_packet_match
                       && st_ff.magic_packet_wake_enable;
    end

    // register read views
    always_comb begin
        wake_view                 = WAKE_RESET;
        wake_view[WAKE_GUE_BIT]   = st_ff.global_unicast_wake_enable;
        wake_view[WAKE_WAKE_FRAME_RECEIVED_BIT]  = st_ff.wake_frame_received;
        wake_view[WAKE_MPR_BIT]   = st_ff.magic_packet_received;
        wake_view[WAKE_WAKE_FRAME_ENABLE_BIT]  = st_ff.wake_frame_enable;
        wake_view[WAKE_MAGIC_PACKET_WAKE_ENABLE_BIT]  = st_ff.magic_packet_wake_enable;
        csum_view                   = CSUM_RESET;
        csum_view[CSUM_TX_EN_BIT]   = st_ff.csum.tx_checksum_engine_enable;
        csum_view[CSUM_RX_MODE_BIT] = st_ff.csum.rx_checksum_start_mode;
        csum_view[CSUM_RX_EN_BIT]   = st_ff.csum.rx_checksum_engine_enable;
        acc_view                    = 32'h0000_0000;
        acc_view[PHY_ACC_INDEX_LSB +: PHY_INDEX_W] = st_ff.acc_index;
        acc_view[PHY_ACC_WRITE_BIT] = st_ff.acc_write;
        acc_view[PHY_ACC_BUSY_BIT]  = st_ff.acc_busy;
    end

    always_comb begin
        nxt_st             = st_ff;
        nxt_st.rdata_valid = 1'b0;
        nxt_st.wake        = 1'b0;
        phy_wr             = 1'b0;

        // wake enables and flag clearing by writing one
        if (csr_wr_i && hit_wake) begin
            nxt_st.global_unicast_wake_enable  = csr_wdata_i[WAKE_GUE_BIT];
            nxt_st.wake_frame_enable = csr_wdata_i[WAKE_WAKE_FRAME_ENABLE_BIT];
            nxt_st.magic_packet_wake_enable = csr_wdata_i[WAKE_MAGIC_PACKET_WAKE_ENABLE_BIT];
            if (csr_wdata_i[WAKE_WAKE_FRAME_RECEIVED_BIT]) begin
                nxt_st.wake_frame_received = 1'b0;
            end
            if (csr_wdata_i[WAKE_MPR_BIT]) begin
                nxt_st.magic_packet_received = 1'b0;
            end
        end
        // set after clear so a same-cycle event is kept
        // wake frame and magic flags, then the wake pulse
        if (wake_frame_hit) begin
            nxt_st.wake_frame_received = 1'b1;
        end
        if (magic_hit) begin
            nxt_st.magic_packet_received = 1'b1;
        end
        if (power_save_i && (unicast_hit || wake_frame_hit || magic_hit)) begin
            nxt_st.wake = 1'b1;
        end

        // engines are not interlocked with the data paths; software owns that
        if (csr_wr_i && hit_csum) begin
            nxt_st.csum.tx_checksum_engine_enable = csr_wdata_i[CSUM_TX_EN_BIT];
            nxt_st.csum.rx_checksum_start_mode    = csr_wdata_i[CSUM_RX_MODE_BIT];
            nxt_st.csum.rx_checksum_engine_enable = csr_wdata_i[CSUM_RX_EN_BIT];
        end
        // fixed skip or hunt for L3
        nxt_st.skip = nxt_st.csum.rx_checksum_start_mode ? 8'h00 : RX_CSUM_FIXED_SKIP;

        // indirect PHY access, one busy cycle
        if (st_ff.acc_busy) begin
            nxt_st.acc_busy = 1'b0;
            if (st_ff.acc_write) begin
                phy_wr = 1'b1;
            end else begin
                nxt_st.phy_data = phy_rdata;
            end
        end else if (csr_wr_i && hit_acc) begin
            nxt_st.acc_index = csr_wdata_i[PHY_ACC_INDEX_LSB +: PHY_INDEX_W];
            nxt_st.acc_write = csr_wdata_i[PHY_ACC_WRITE_BIT];
            nxt_st.acc_busy  = csr_wdata_i[PHY_ACC_BUSY_BIT];
        end else if (csr_wr_i && hit_data) begin
            nxt_st.phy_data = csr_wdata_i[15:0];
        end

        if (csr_rd_i) begin
            nxt_st.rdata_valid = 1'b1;
            if (hit_wake) begin
                nxt_st.rdata = wake_view;
            end else if (hit_csum) begin
                nxt_st.rdata = csum_view;
            end else if (hit_acc) begin
                nxt_st.rdata = acc_view;
            end else if (hit_data) begin
                nxt_st.rdata = {16'h0000, st_ff.phy_data};
            end else begin
                nxt_st.rdata = 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_ff      <= '0;
            st_ff.skip <= RX_CSUM_FIXED_SKIP;
        end else begin
            st_ff <= nxt_st;
        end
    end

    phy_basic_control u_phy_basic_control (
        .sys_clk_i             (sys_clk_i),
        .rst_b_i               (rst_b_i),
        .reg_wr_i              (phy_wr),
        .reg_index_i           (st_ff.acc_index),
        .reg_wdata_i           (st_ff.phy_data),
        .reg_rdata_o           (phy_rdata),
        .partner_ok_i          (partner_ok_i),
        .partner_speed_100_i   (partner_speed_100_i),
        .partner_full_duplex_i (partner_full_duplex_i),
        .phy_mode_o            (phy_mode_o)
    );

    assign csr_rdata_o        = st_ff.rdata;
    assign csr_rdata_valid_o  = st_ff.rdata_valid;
    assign wake_o             = st_ff.wake;
    assign checksum_o         = st_ff.csum;
    assign rx_checksum_skip_o = st_ff.skip;

endmodule

// ### tb/wake_coe_phy_control_regs_chk.sv
`timescale 1ns/10ps
module wake_coe_phy_control_regs_chk
    import wake_coe_pkg::*;
(
    // clock and reset
    input  wire logic           sys_clk_i,
    input  wire logic           rst_b_i,
    // register port
    input  wire logic           csr_wr_i,
    input  wire logic           csr_rd_i,
    input  wire logic [7:0]     csr_index_i,
    input  wire logic [31:0]    csr_wdata_i,
    input  wire logic [31:0]    csr_rdata_o,
    input  wire logic           csr_rdata_valid_o,
    // events and modes
    input  wire rx_wake_event_s rx_event_i,
    input  wire logic           power_save_i,
    input  wire logic           wake_o,
    input  wire checksum_ctrl_s checksum_o,
    input  wire logic [7:0]     rx_checksum_skip_o,
    input  wire logic           partner_ok_i,
    input  wire logic           partner_speed_100_i,
    input  wire logic           partner_full_duplex_i,
    input  wire phy_mode_s      phy_mode_o
);
    // shadow of {unicast, frame, magic} wake enables
    logic [2:0] wake_en_ff;
    logic       wake_cause;
    logic       csum_wr;

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wake_en_ff <= 3'h0;
        end else if (csr_wr_i && csr_index_i == CSR_WAKE_IDX) begin
            wake_en_ff <= {csr_wdata_i[9], csr_wdata_i[2], csr_wdata_i[1]};
        end
    end

    assign wake_cause = rx_event_i.rx_frame_done && power_save_i &&
        ((wake_en_ff[2] && !rx_event_i.dest_addr_lsb) ||
         (wake_en_ff[1] && rx_event_i.wake_frame_match) ||
         (wake_en_ff[0] && rx_event_i.magic_packet_match));
    assign csum_wr = csr_wr_i && csr_index_i == CSR_CHECKSUM_IDX;

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);

    a_read_gets_valid: assert property (csr_rd_i |=> csr_rdata_valid_o)
        else $error("read strobe without valid");
    a_valid_needs_read: assert property (csr_rdata_valid_o |-> $past(csr_rd_i))
        else $error("valid without read strobe");
    a_wake_on_cause: assert property (wake_cause |=> wake_o)
        else $error("wake missing");
    a_wake_needs_cause: assert property (wake_o |-> $past(wake_cause))
        else $error("spurious wake");
    a_csum_follows_write: assert property (csum_wr |=> checksum_o ==
        $past({csr_wdata_i[16], csr_wdata_i[0], csr_wdata_i[1]}))
        else $error("checksum control wrong");
    a_csum_holds: assert property (!csum_wr |=> $stable(checksum_o))
        else $error("checksum control moved");
    a_skip_by_mode: assert property (rx_checksum_skip_o ==
        (checksum_o.rx_checksum_start_mode ? 8'h00 : RX_CSUM_FIXED_SKIP))
        else $error("skip count wrong");
    a_soft_reset_pulse: assert property (phy_mode_o.soft_reset |=> !phy_mode_o.soft_reset)
        else $error("soft reset stuck");
    a_restart_pulse: assert property (phy_mode_o.an_restart |=> !phy_mode_o.an_restart)
        else $error("restart stuck");
    a_pdown_not_done: assert property (phy_mode_o.power_down |-> !phy_mode_o.an_complete)
        else $error("done while powered down");
endmodule

bind wake_coe_phy_control_regs wake_coe_phy_control_regs_chk u_chk (
    .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .csr_wr_i(csr_wr_i), .csr_rd_i(csr_rd_i),
    .csr_index_i(csr_index_i), .csr_wdata_i(csr_wdata_i), .csr_rdata_o(csr_rdata_o),
    .csr_rdata_valid_o(csr_rdata_valid_o), .rx_event_i(rx_event_i),
    .power_save_i(power_save_i), .wake_o(wake_o), .checksum_o(checksum_o),
    .rx_checksum_skip_o(rx_checksum_skip_o), .partner_ok_i(partner_ok_i),
    .partner_speed_100_i(partner_speed_100_i),
    .partner_full_duplex_i(partner_full_duplex_i), .phy_mode_o(phy_mode_o));

// ### tb/testbench.sv
`timescale 1ns/10ps
module testbench
    import wake_coe_pkg::*;
;
    logic           sys_clk_i, rst_b_i, csr_wr_i, csr_rd_i, power_save_i, wake_o;
    logic [7:0]     csr_index_i, rx_checksum_skip_o;
    logic [31:0]    csr_wdata_i, csr_rdata_o, junk;
    logic           csr_rdata_valid_o, partner_ok_i, partner_speed_100_i, partner_full_duplex_i;
    rx_wake_event_s rx_event_i, ev;
    checksum_ctrl_s checksum_o;
    phy_mode_s      phy_mode_o;
    logic [31:0]    exp_q[$];
    logic [15:0]    d;
    logic [2:0]     en;
    logic [1:0]     flags;
    int             n_errors, checked, cycles;

    wake_coe_phy_control_regs u_wake_coe_phy_control_regs (
        .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .csr_wr_i(csr_wr_i), .csr_rd_i(csr_rd_i),
        .csr_index_i(csr_index_i), .csr_wdata_i(csr_wdata_i), .csr_rdata_o(csr_rdata_o),
        .csr_rdata_valid_o(csr_rdata_valid_o), .rx_event_i(rx_event_i),
        .power_save_i(power_save_i), .wake_o(wake_o), .checksum_o(checksum_o),
        .rx_checksum_skip_o(rx_checksum_skip_o), .partner_ok_i(partner_ok_i),
        .partner_speed_100_i(partner_speed_100_i),
        .partner_full_duplex_i(partner_full_duplex_i), .phy_mode_o(phy_mode_o));

    initial sys_clk_i = 1'b0;
    always #20 sys_clk_i = ~sys_clk_i;

    task automatic summarize();
        if (n_errors == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // tasks start and end just after a rising edge
    // idle edge after each strobe, so back-to-back calls never merge into one long strobe
    task automatic csr_write(input logic [7:0] idx, input logic [31:0] data);
        csr_wr_i = 1'b1;
        csr_index_i = idx;
        csr_wdata_i = data;
        @(posedge sys_clk_i);
        #1 csr_wr_i = 1'b0;
        @(posedge sys_clk_i);
        #1;
    endtask

    task automatic csr_read(input logic [7:0] idx, input logic [31:0] exp);
        csr_rd_i = 1'b1;
        csr_index_i = idx;
        exp_q.push_back(exp);
        @(posedge sys_clk_i);
        #1 csr_rd_i = 1'b0;
        @(posedge sys_clk_i);
        #1;
    endtask

    task automatic phy_write(input logic [4:0] idx, input logic [15:0] data);
        csr_write(CSR_PHY_DATA_IDX, {16'h0, data});
        csr_write(CSR_PHY_ACCESS_IDX, {21'h0, idx, 6'h3});
        repeat (3) @(posedge sys_clk_i);
        #1;
    endtask

    task automatic phy_read(input logic [4:0] idx, input logic [15:0] exp);
        csr_write(CSR_PHY_ACCESS_IDX, {21'h0, idx, 6'h1});
        repeat (3) @(posedge sys_clk_i);
        #1 csr_read(CSR_PHY_DATA_IDX, {16'h0, exp});
    endtask

    // read answers are paired with the oldest note
    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            summarize();
        end
        if (csr_rdata_valid_o === 1'b1) begin
            if (exp_q.size() == 0) begin
                n_errors++;
                $display("mismatch at %0t: unexpected read answer", $time);
            end else begin
                check(csr_rdata_o, exp_q.pop_front());
            end
        end
    end

    initial begin
        {rst_b_i, csr_wr_i, csr_rd_i, power_save_i, partner_ok_i} = 5'h0;
        {partner_speed_100_i, partner_full_duplex_i, csr_index_i, csr_wdata_i} = 42'h0;
        rx_event_i = '0;
        flags = 2'h0;
        void'($urandom(4521));
        repeat (20) @(posedge sys_clk_i);
        #1 rst_b_i = 1'b1;
        csr_read(CSR_WAKE_IDX, 32'h0);
        csr_write(8'h20, 32'hffff_ffff);
        csr_read(8'h20, 32'h0);
        for (int i = 0; i < 16; i++) begin
            en = 3'($urandom);
            csr_write(CSR_WAKE_IDX, {22'h0, en[2], 6'h0, en[1], en[0], 1'b0});
            ev = rx_wake_event_s'(4'($urandom));
            ev.rx_frame_done = 1'b1;
            power_save_i = 1'($urandom);
            rx_event_i = ev;
            @(posedge sys_clk_i);
            #1 rx_event_i = '0;
            check({31'h0, wake_o}, {31'h0, power_save_i && ((en[2] && !ev.dest_addr_lsb) ||
                (en[1] && ev.wake_frame_match) || (en[0] && ev.magic_packet_match))});
            flags = flags | {en[1] && ev.wake_frame_match, en[0] && ev.magic_packet_match};
            csr_read(CSR_WAKE_IDX, {22'h0, en[2], 2'h0, flags, 2'h0, en[1:0], 1'b0});
        end
        // ones everywhere: flags clear, reserved bits stay zero
        csr_write(CSR_WAKE_IDX, 32'hffff_ffff);
        csr_read(CSR_WAKE_IDX, 32'h0000_0206);
        for (int i = 0; i < 8; i++) begin
            en = 3'(i);
            junk = $urandom & 32'hfffe_fffc;
            csr_write(CSR_CHECKSUM_IDX, junk | {15'h0, en[2], 14'h0, en[1:0]});
            check({29'h0, checksum_o}, {29'h0, en[2], en[0], en[1]});
            check({24'h0, rx_checksum_skip_o}, en[1] ? 32'h0 : 32'he);
            csr_read(CSR_CHECKSUM_IDX, {15'h0, en[2], 14'h0, en[1:0]});
        end
        phy_read(PHY_IDX_BASIC_CTRL, BCR_RESET);
        phy_read(PHY_IDX_BASIC_STAT, BSR_FIXED);
        phy_write(PHY_IDX_MODE_CTRL, 16'hffff);
        phy_read(PHY_IDX_MODE_CTRL, 16'h0);
        for (int i = 0; i < 6; i++) begin
            d = 16'($urandom) & 16'h65ff;
            phy_write(PHY_IDX_BASIC_CTRL, d);
            phy_read(PHY_IDX_BASIC_CTRL, d & BCR_STORE_MASK);
            check({28'h0, phy_mode_o.loopback, phy_mode_o.speed_100, phy_mode_o.full_duplex,
                phy_mode_o.collision_test}, {28'h0, d[14], d[13], d[8], d[7]});
        end
        {partner_speed_100_i, partner_full_duplex_i} = 2'($urandom);
        phy_write(PHY_IDX_BASIC_CTRL, 16'h1000);
        partner_ok_i = 1'b1;
        repeat (6) @(posedge sys_clk_i);
        #1 phy_read(PHY_IDX_BASIC_STAT, BSR_FIXED | 16'h0024);
        phy_read(PHY_IDX_BASIC_CTRL, {2'h0, partner_speed_100_i, 4'h8, partner_full_duplex_i,
            8'h0});
        check({29'h0, phy_mode_o.speed_100, phy_mode_o.full_duplex, phy_mode_o.an_complete},
            {29'h0, partner_speed_100_i, partner_full_duplex_i, 1'b1});
        phy_write(PHY_IDX_BASIC_CTRL, 16'h1200);
        phy_write(PHY_IDX_BASIC_CTRL, 16'h1800);
        phy_read(PHY_IDX_BASIC_STAT, BSR_FIXED | 16'h0004);
        check({31'h0, phy_mode_o.power_down}, 32'h1);
        // partner gone, so negotiation stays running after the reset
        partner_ok_i = 1'b0;
        phy_write(PHY_IDX_BASIC_CTRL, 16'h8000);
        phy_read(PHY_IDX_BASIC_CTRL, BCR_RESET | KEPT_OVER_SOFT_RESET);
        check({31'h0, phy_mode_o.power_down}, 32'h0);
        repeat (3) @(posedge sys_clk_i);
        check(exp_q.size(), 32'h0);
        summarize();
    end
endmodule
